// File: cwoc_top.sv
/*
 * Current window and off-time controller: APB registers, window
 * period generator, minimum off-time timer and current-mode PWM.
 * Assumes a zero-wait APB master and comparator levels synchronous
 * to pclk. CLK_HZ is the pclk rate; all timings scale with it.
 */
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module cwoc_top import cwoc_pkg::*; #(
    parameter longint CLK_HZ = `CWOC_CLK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic opamp_output_pin,
    input wire logic direct_feedback_pin,
    output logic opamp_enable,
    output logic cmp_input_select,
    output logic pwm_out,
    output logic meas_window,
    output logic bemf_window
);
    // Sixteen 16-bit divisors packed in one word, code 0 lowest.
    localparam logic [255:0] WIN_DIVS = `CWOC_WIN_DIVS;

    cwoc_st_t st_q;
    cwoc_st_t st_d;

    logic cur_mode;
    logic sensor_mode_bit;
    logic on_time_sampling_bit;
    logic [3:0] window_freq_sel;
    logic [3:0] min_offtime_sel;
    logic [3:0] sample_delay_field;
    logic zero_off;
    logic [15:0] per_cyc;
    logic [15:0] off_cyc;
    logic full_duty;
    logic per_busy;
    logic per_done;
    logic per_start;
    logic off_busy;
    logic off_done;
    logic off_start;
    logic cmp_enabled;
    logic cmp_hit;
    logic wr_en;
    logic rd_hit;

    // ---------------------------------------------------------------
    // Timing conversion
    // ---------------------------------------------------------------
    // Period in pclk cycles; a longest figure, so it rounds down.
    function automatic logic [15:0] period_cycles(input logic [3:0] s);
        longint c;
        c = (longint'(WIN_DIVS[{s, 4'h0} +: 16]) * CLK_HZ) /
            `CWOC_REF_HZ;
        if (c < 1) begin
            c = 1;
        end
        return 16'(c);
    endfunction

    // Off time in pclk cycles; a least figure, so it rounds up.
    function automatic logic [15:0] offtime_cycles(input logic [3:0] s);
        longint ns;
        longint c;
        ns = (longint'(s) + 1) * `CWOC_OFF_STEP_NS;
        c = (ns * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
        if (c < 1) begin
            c = 1;
        end
        return 16'(c);
    endfunction

    // ---------------------------------------------------------------
    // Field decode
    // ---------------------------------------------------------------
    // Register fields steering the generator.
    assign opamp_enable = st_q.ctrl[`CWOC_CTRL_OPAMP_EN];
    assign cmp_input_select = st_q.ctrl[`CWOC_CTRL_CMP_SEL];
    assign cur_mode = st_q.ctrl[`CWOC_CTRL_CUR_MODE];
    assign sensor_mode_bit = st_q.ctrl[`CWOC_CTRL_SENSOR];
    assign on_time_sampling_bit = st_q.ctrl[`CWOC_CTRL_ONSAMP];
    assign window_freq_sel = st_q.tim[`CWOC_TIM_FREQ_LSB +: 4];
    assign min_offtime_sel = st_q.tim[`CWOC_TIM_OFF_LSB +: 4];
    assign sample_delay_field = st_q.tim[`CWOC_TIM_DELAY_LSB +: 4];

    // No minimum off time when the current loop alone rules.
    assign zero_off = sensor_mode_bit | on_time_sampling_bit |
        (sample_delay_field != 4'h0);

    // Cycle counts at the current clock rate.
    assign per_cyc = period_cycles(window_freq_sel);
    assign off_cyc = offtime_cycles(min_offtime_sel);

    // An off time as long as the period or longer would never close.
    assign full_duty = !zero_off && (off_cyc >= per_cyc);

    // ---------------------------------------------------------------
    // Timers
    // ---------------------------------------------------------------
    // Period restarts itself; the off timer starts with each period unless zero_off or full_duty is set.
    assign per_start = cur_mode && (!per_busy || per_done);
    assign off_start = per_start && !zero_off && !full_duty;

    cwoc_timer u_period (
        .pclk(pclk),
        .presetn(presetn),
        .start(per_start),
        .load(per_cyc),
        .busy(per_busy),
        .done(per_done)
    );

    cwoc_timer u_offtime (
        .pclk(pclk),
        .presetn(presetn),
        .start(off_start),
        .load(off_cyc),
        .busy(off_busy),
        .done(off_done)
    );

    cwoc_cmp_path u_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .opamp_output_pin(opamp_output_pin),
        .direct_feedback_pin(direct_feedback_pin),
        .cmp_input_select(cmp_input_select),
        .timer_clk_enable(st_q.ctrl[`CWOC_CTRL_TCLK_EN]),
        .direct_access(st_q.ctrl[`CWOC_CTRL_DIRECT]),
        .cmp_enabled(cmp_enabled),
        .cmp_hit(cmp_hit)
    );

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with an error.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_hit = (paddr == `CWOC_CTRL_OFS) ||
        (paddr == `CWOC_TIMING_OFS) || (paddr == `CWOC_STATUS_OFS);
    assign pslverr = psel && penable && !rd_hit;

    // Read mux; reserved bits read as zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            unique case (paddr)
                `CWOC_CTRL_OFS: prdata[`CWOC_CTRL_W-1:0] = st_q.ctrl;
                `CWOC_TIMING_OFS: prdata[`CWOC_TIM_W-1:0] = st_q.tim;
                `CWOC_STATUS_OFS: prdata[5:0] = {cmp_enabled, full_duty,
                    cmp_hit, st_q.win, st_q.pwm, st_q.run};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Generator and registers
    // ---------------------------------------------------------------
    // The window opens at each period start unless zero_off or full_duty is set;
    // PWM turns on when it closes and off at the next period or when current is reached.
    always_comb begin
        st_d = st_q;
        if (wr_en && paddr == `CWOC_CTRL_OFS) begin
            st_d.ctrl = pwdata[`CWOC_CTRL_W-1:0];
        end
        if (wr_en && paddr == `CWOC_TIMING_OFS) begin
            st_d.tim = pwdata[`CWOC_TIM_W-1:0];
        end
        st_d.run = cur_mode;
        if (!cur_mode) begin
            st_d.pwm = 1'b0;
            st_d.win = 1'b0;
        end else if (full_duty) begin
            st_d.pwm = 1'b1;
            st_d.win = 1'b0;
        end else if (per_start) begin
            // With zero off time ON begins with the period itself.
            st_d.win = !zero_off;
            st_d.pwm = zero_off && !cmp_hit;
        end else if (off_done) begin
            st_d.win = 1'b0;
            st_d.pwm = !cmp_hit;
        end else if (st_q.pwm && cmp_hit) begin
            st_d.pwm = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.ctrl <= `CWOC_CTRL_RST;
            st_q.tim <= `CWOC_TIM_RST;
            st_q.pwm <= 1'b0;
            st_q.win <= 1'b0;
            st_q.run <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come from flops; bemf_window also masks the window with the sensor mode bit.
    assign pwm_out = st_q.pwm;
    assign meas_window = st_q.win;
    assign bemf_window = st_q.win && !sensor_mode_bit;
endmodule

// File: cwoc_params.svh
/*
 * Constants of the current window and off-time controller: register
 * offsets, field positions, reset values and timing figures.
 * Assumes it is included by bare name from the package and the bench.
 */
`ifndef CWOC_PARAMS_SVH
`define CWOC_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define CWOC_CTRL_OFS 12'h000
`define CWOC_TIMING_OFS 12'h004
`define CWOC_STATUS_OFS 12'h008

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CWOC_CTRL_OPAMP_EN 0
`define CWOC_CTRL_CMP_SEL 1
`define CWOC_CTRL_CUR_MODE 2
`define CWOC_CTRL_SENSOR 3
`define CWOC_CTRL_ONSAMP 4
`define CWOC_CTRL_TCLK_EN 5
`define CWOC_CTRL_DIRECT 6
`define CWOC_CTRL_W 7
`define CWOC_CTRL_RST 7'h00

// ---------------------------------------------------------------
// Timing register fields
// ---------------------------------------------------------------
`define CWOC_TIM_FREQ_LSB 0
`define CWOC_TIM_OFF_LSB 4
`define CWOC_TIM_DELAY_LSB 8
`define CWOC_TIM_W 12
`define CWOC_TIM_RST 12'h000

// ---------------------------------------------------------------
// Timing figures
// ---------------------------------------------------------------
`define CWOC_REF_HZ 4000000
`define CWOC_CLK_HZ 10000000
`define CWOC_OFF_STEP_NS 2500
// Window periods in reference clock ticks, code 0 to 15.
`define CWOC_WIN_DIVS {16'd10240, 16'd6400, 16'd4160, 16'd3200, \
    16'd2560, 16'd1280, 16'd640, 16'd400, 16'd320, 16'd260, \
    16'd220, 16'd200, 16'd160, 16'd120, 16'd100, 16'd80}

`endif

// File: cwoc_pkg.sv
/*
 * Types of the current window and off-time controller.
 * Assumes the constants header is on the include path.
 */
package cwoc_pkg;
`include "cwoc_params.svh"

    // Down-counter state.
    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
    } cwoc_tmr_st_t;

    // Comparator path state.
    typedef struct packed {
        logic en;
        logic hit;
    } cwoc_cmp_st_t;

    // Main state.
    typedef struct packed {
        logic [`CWOC_CTRL_W-1:0] ctrl;
        logic [`CWOC_TIM_W-1:0] tim;
        logic pwm;
        logic win;
        logic run;
    } cwoc_st_t;
endpackage

// File: cwoc_timer.sv
/*
 * Loadable down counter: start loads a count, done pulses on its
 * last cycle. Assumes load is at least one.
 */
`timescale 1ns/1ns
module cwoc_timer import cwoc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [15:0] load,
    output logic busy,
    output logic done
);
    cwoc_tmr_st_t st_q;
    cwoc_tmr_st_t st_d;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // A restart wins over the running count so periods never slip.
    always_comb begin
        st_d = st_q;
        if (start) begin
            st_d.cnt = load;
            st_d.busy = 1'b1;
        end else if (st_q.busy) begin
            st_d.cnt = st_q.cnt - 16'h0001;
            if (st_q.cnt == 16'h0001) begin
                st_d.busy = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Done leaves start out: an owner that builds start from done
    // would otherwise close a combinational loop.
    assign busy = st_q.busy;
    assign done = st_q.busy && (st_q.cnt == 16'h0001);
endmodule

// File: cwoc_cmp_path.sv
/*
 * Comparator input selection and enable gating.
 * Assumes both comparator results are synchronous to pclk.
 */
`timescale 1ns/1ns
module cwoc_cmp_path import cwoc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic opamp_output_pin,
    input wire logic direct_feedback_pin,
    input wire logic cmp_input_select,
    input wire logic timer_clk_enable,
    input wire logic direct_access,
    output logic cmp_enabled,
    output logic cmp_hit
);
    cwoc_cmp_st_t st_q;
    cwoc_cmp_st_t st_d;

    // ---------------------------------------------------------------
    // Selection and gating
    // ---------------------------------------------------------------
    // A disabled comparator reads as no current, so it never cuts PWM.
    always_comb begin
        st_d = st_q;
        st_d.en = timer_clk_enable | direct_access;
        st_d.hit = st_d.en &&
            (cmp_input_select ? direct_feedback_pin
                              : opamp_output_pin);
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cmp_enabled = st_q.en;
    assign cmp_hit = st_q.hit;
endmodule

// File: cwoc_top_assertions.sv
/* Checker for the window and off-time controller top ports.
 * Assumes it is bound into cwoc_top with CLK_HZ handed on. */
`timescale 1ns/1ns
module cwoc_top_chk #(
    parameter longint CLK_HZ = 10000000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic opamp_enable,
    input wire logic cmp_input_select,
    input wire logic pwm_out,
    input wire logic meas_window,
    input wire logic bemf_window
);
    // Longest window is sixteen off-time steps, rounded up to cycles.
    localparam longint WMAX = (CLK_HZ * 4 + 99999) / 100000;
    logic wr_ctrl;
    logic [15:0] win_len_q;
    assign wr_ctrl = psel && penable && pready && pwrite && paddr == 12'h000;
    // A counter stands in for a long repetition the tools would unroll.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_len_q <= 16'h0000;
        end else begin
            win_len_q <= meas_window ? win_len_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SEL_WR:
    assert property (wr_ctrl |=> cmp_input_select == $past(pwdata[1]))
        else $error("Select output missed a control write.");
    AST_SEL_HOLD:
    assert property (!wr_ctrl |=> $stable(cmp_input_select))
        else $error("Select output moved without a write.");
    AST_OPA_WR:
    assert property (wr_ctrl |=> opamp_enable == $past(pwdata[0]))
        else $error("Amplifier enable missed a control write.");
    AST_OPA_HOLD:
    assert property (!wr_ctrl |=> $stable(opamp_enable))
        else $error("Amplifier enable moved without a write.");
    AST_BEMF:
    assert property (bemf_window |-> meas_window)
        else $error("Zero-crossing window outside the window.");
    AST_WIN_OFF:
    assert property (meas_window |-> !pwm_out)
        else $error("Output on during the off window.");
    AST_PERIOD:
    assert property ($rose(meas_window) |=> (!$rose(meas_window)) [*7])
        else $error("Windows opened too close together.");
    AST_WIN_MAX:
    assert property (win_len_q <= WMAX)
        else $error("Window longer than the largest off time.");
endmodule

// File: cwoc_partner.sv
/* Power stage and current sense model: current ramps while pwm_out
 * is high. Assumes pwm_out is a level synchronous to pclk. */
`timescale 1ns/1ns
module cwoc_partner #(
    parameter int RAMP_A = 3,
    parameter int RAMP_B = 6
) (
    input wire logic pclk,
    input wire logic pwm_out,
    output logic opamp_output_pin,
    output logic direct_feedback_pin
);
    // -----------------------------------------------------------
    // Current ramp
    // -----------------------------------------------------------
    int amp = 0;
    // Current collapses at once when the switch opens, a coarse model.
    always @(posedge pclk) begin
        amp <= pwm_out ? amp + 1 : 0;
    end
    // The amplified path trips sooner, so the two paths differ.
    assign opamp_output_pin = (amp >= RAMP_A);
    assign direct_feedback_pin = (amp >= RAMP_B);
endmodule

// File: test_current_window_offtime_ctrl.sv
/* Self-checking bench for cwoc_top over APB with a stage model.
 * Assumes the constants header is on the include path. */
`timescale 1ns/1ns
`include "cwoc_params.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module test_current_window_offtime_ctrl import cwoc_pkg::*; ;
    // Slow clock rate keeps every count short.
    localparam longint HZ = 400000;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, opa_pin, dir_pin, opamp_enable;
    logic cmp_input_select, pwm_out, meas_window, bemf_window;
    int errors = 0;
    int checks_done = 0;
    int c, w, h, ho, i, p;
    int rf[16] = '{80, 100, 120, 160, 200, 220, 260, 320, 400, 640,
        1280, 2560, 3200, 4160, 6400, 10240};
    always #50 pclk = ~pclk;
    cwoc_top #(.CLK_HZ(HZ)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .opamp_output_pin(opa_pin),
        .direct_feedback_pin(dir_pin), .opamp_enable(opamp_enable),
        .cmp_input_select(cmp_input_select), .pwm_out(pwm_out),
        .meas_window(meas_window), .bemf_window(bemf_window));
    cwoc_partner i_stage (.pclk(pclk), .pwm_out(pwm_out),
        .opamp_output_pin(opa_pin), .direct_feedback_pin(dir_pin));
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    // Cycles to the next window opening, sampled mid-cycle. The first
    // sample counts, so back-to-back calls span one whole period.
    task automatic nxt_rise();
        logic pv;
        @(negedge pclk);
        c = 1;
        w = meas_window;
        h = pwm_out;
        do begin
            pv = meas_window;
            @(negedge pclk);
            c++;
            w += meas_window;
            h += pwm_out;
            if (c > 3000) begin
                errors++;
                complete_run();
            end
        end while (!(pv === 1'b0 && meas_window === 1'b1));
    endtask
    task automatic span(input int n);
        w = 0;
        h = 0;
        repeat (n) begin
            @(negedge pclk);
            w += meas_window;
            h += pwm_out;
        end
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`CWOC_CTRL_OFS, 32'h0000_0000);
        rchk(`CWOC_TIMING_OFS, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK(er, 1'b1)
        apb(1'b1, `CWOC_CTRL_OFS, 32'hFFFF_FFFF);
        rchk(`CWOC_CTRL_OFS, 32'h0000_007F);
        `CHK({opamp_enable, cmp_input_select}, 2'b11)
        apb(1'b1, `CWOC_CTRL_OFS, 32'h0000_0005);
        @(negedge pclk);
        `CHK({opamp_enable, cmp_input_select}, 2'b10)
        apb(1'b1, `CWOC_CTRL_OFS, 32'h0000_0004);
        @(negedge pclk);
        `CHK({opamp_enable, cmp_input_select}, 2'b00)
        $display("Test registers done");
        for (i = 0; i < 16; i++) begin
            apb(1'b1, `CWOC_TIMING_OFS, i);
            repeat (3) nxt_rise();
            p = rf[i] * HZ / 4000000;
            `CHK(c, p)
            `CHK(h, p - 1)
        end
        $display("Test window periods done");
        for (i = 0; i < 16; i++) begin
            apb(1'b1, `CWOC_TIMING_OFS, 32'h0000_0009 | (i << 4));
            repeat (3) nxt_rise();
            `CHK(bemf_window, 1'b1)
            p = ((i + 1) * HZ + 399999) / 400000;
            `CHK(w, p)
            `CHK(h, 64 - p)
        end
        $display("Test off times done");
        apb(1'b1, `CWOC_TIMING_OFS, 32'h0000_0007);
        apb(1'b1, `CWOC_CTRL_OFS, 32'h0000_0024);
        apb(1'b0, `CWOC_STATUS_OFS, 32'h0000_0000);
        `CHK(rd[5], 1'b1)
        repeat (3) nxt_rise();
        ho = h;
        apb(1'b1, `CWOC_CTRL_OFS, 32'h0000_0046);
        repeat (3) nxt_rise();
        `CHK(ho < h, 1'b1)
        `CHK(h < 31, 1'b1)
        $display("Test comparator done");
        for (i = 0; i < 3; i++) begin
            apb(1'b1, `CWOC_CTRL_OFS, i == 0 ? 32'h0000_000C :
                i == 1 ? 32'h0000_0014 : 32'h0000_0004);
            apb(1'b1, `CWOC_TIMING_OFS, i == 2 ? 32'h0000_0107 : 32'h7);
            span(40);
            span(64);
            `CHK(w, 0)
            `CHK(h > 0, 1'b1)
        end
        apb(1'b1, `CWOC_TIMING_OFS, 32'h0000_00F0);
        span(40);
        span(64);
        `CHK(h, 64)
        `CHK(w, 0)
        apb(1'b0, `CWOC_STATUS_OFS, 32'h0000_0000);
        `CHK(rd[4], 1'b1)
        $display("Test zero and full off done");
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        `CHK({pwm_out, opamp_enable, cmp_input_select, meas_window}, 4'h0)
        @(posedge pclk);
        presetn <= 1'b1;
        rchk(`CWOC_CTRL_OFS, 32'h0000_0000);
        $display("Test second reset done");
        complete_run();
    end
endmodule
bind cwoc_top cwoc_top_chk #(.CLK_HZ(CLK_HZ)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .opamp_enable(opamp_enable), .cmp_input_select(cmp_input_select),
    .pwm_out(pwm_out), .meas_window(meas_window),
    .bemf_window(bemf_window));
